//--- serial_control_port_pkg.sv
// Shared constants and types of the serial control port.
`default_nettype none
package serial_control_port_pkg;
	// ==========================================================
	// Register offsets.
	localparam logic [7:0] ADDR_CH0_SIC = 8'h20;
	localparam logic [7:0] ADDR_CH1_SIC = 8'h40;
	localparam logic [7:0] ADDR_DATA = 8'h48;
	localparam logic [7:0] ADDR_CTRL = 8'h49;
	localparam logic [7:0] ADDR_RX_FIFO = 8'h4a;
	localparam logic [7:0] ADDR_FIFO_STAT = 8'h4b;
	// ==========================================================
	// Field positions.
	localparam int SIC_PORT_EN = 0;
	localparam int SIC_SLAVE = 1;
	localparam int CTRL_SEL0 = 0;
	localparam int CTRL_SEL1 = 1;
	localparam int CTRL_XMIT = 2;
	localparam int CTRL_DONE = 3;
	localparam int CTRL_IE = 4;
	localparam int CTRL_CLOCK_INVERT = 5;
	localparam int CTRL_RATE_LO = 6;
	localparam int STAT_OVR = 7;
	// ==========================================================
	// Reset values and sizes.
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] BUSY_READ = 8'h00;
	localparam int WORD_BITS = 8;
	localparam int FIFO_WORDS = 8;
	// ==========================================================
	// Timing: half serial clock period in system clocks for each rate tap.
	localparam int TAP0_HALF = 1;
	localparam int TAP1_HALF = 2;
	localparam int TAP2_HALF = 4;
	localparam int TAP3_HALF = 8;
	localparam int DIV_BITS = 3;
	// ==========================================================
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} host_req_s;
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_WAIT = 2'b01,
		M_RUN = 2'b11
	} master_state_e;
endpackage
`default_nettype wire

//--- scp_word_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
`default_nettype none
module rx_word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH)
		$error("FIFO depth must be a power of two of at least two.");
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wptr_reg;
	logic [AW-1:0] rptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;
	assign in_ready = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[rptr_reg];
	assign level = count_reg;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wptr_reg] <= in_data;
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wptr_reg <= wptr_reg + 1'b1;
			if (pop)
				rptr_reg <= rptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- scp_baud_divider.sv
// Four-tap baud divider giving a half-period tick of the serial clock.
`default_nettype none
module baud_tap_divider (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [1:0] rate,
	output logic tick
);
	localparam int W = serial_control_port_pkg::DIV_BITS;
	logic [W-1:0] cnt_reg;
	logic [W-1:0] mask;
	always_comb
	begin
		case (rate)
			2'd0: mask = W'(serial_control_port_pkg::TAP0_HALF - 1);
			2'd1: mask = W'(serial_control_port_pkg::TAP1_HALF - 1);
			2'd2: mask = W'(serial_control_port_pkg::TAP2_HALF - 1);
			default: mask = W'(serial_control_port_pkg::TAP3_HALF - 1);
		endcase
	end
	assign tick = ((cnt_reg & mask) == mask);
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_reg + 1'b1;
	end
endmodule
`default_nettype wire

//--- serial_control_port.sv
// Serial control port: host registers, master and slave shifting, pin muxing.
`default_nettype none
// What this block does
// R01: Full-duplex 8-bit bursts through one shift register.
// R02: Data writes ignored and reads give 00 while a transfer runs.
// R03: Rate field picks one of four divider taps for the master clock.
// R04: Channel 0 port enable hands its control pins to the port.
// R05: Channel 1 port enable turns its carrier pin into select output 1.
// R06: Master clock idles between bursts, eight pulses per burst.
// R07: Normal polarity: MSB first, drive on rising, sample on falling.
// R08: Inverted clock: drive on falling, sample on rising.
// R09: Host loads data, sets select, sets transmit; received bits replace sent.
// R10: After eighth shift clear transmit and set complete; host clears select.
// R11: Complete flag drives interrupt only when its enable is set.
// R12: Master select pins follow their bits within one clock of the write.
// R13: Shifting starts within one and a half serial clocks of transmit set; the master waits while the receive FIFO is full.
// R14: Host avoids writing within one and a half serial clocks of completion.
// R15: Slave mode: select 0 and clock become inputs, select 1 stays output.
// R16: Slave clock up to half system clock, used only while selected.
// R17: Slave drives MSB on first active edge after select falls.
// R18: Slave raises completion on the rising edge of select.
// R19: Short slave burst leaves old bits moved up, new bits low.
// R20: Long slave burst keeps shifting received data out until deselect.
// R21: External master lowers select only while clock is inactive.
// R22: Slave clock and select are synchronised before edge detection.
module serial_control_port #(
	parameter int FIFO_DEPTH = serial_control_port_pkg::FIFO_WORDS
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire serial_control_port_pkg::host_req_s host_req,
	output logic [7:0] host_rdata,
	output logic irq,
	input wire logic port_serial_in,
	output logic port_serial_out,
	output logic port_serial_out_oe_n,
	input wire logic port_shift_clock_in,
	output logic port_shift_clock_out,
	output logic port_shift_clock_oe_n,
	input wire logic select_out_0_in,
	output logic select_out_0_out,
	output logic select_out_0_oe_n,
	output logic select_out_1,
	output logic select_out_1_oe_n
);
	localparam int WB = serial_control_port_pkg::WORD_BITS;
	localparam int LW = $clog2(FIFO_DEPTH) + 1;
	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64)
		$error("FIFO_DEPTH must lie between 2 and 64.");
	// ==========================================================
	// Control registers.
	logic en0_reg;
	logic slave_reg;
	logic en1_reg;
	logic sel0_n_reg;
	logic sel1_n_reg;
	logic xmit_reg;
	logic done_reg;
	logic ie_reg;
	logic clock_invert_reg;
	logic [1:0] rate_reg;
	logic ovr_reg;
	logic [WB-1:0] shift_reg;
	logic [7:0] rdata_reg;
	logic irq_reg;
	serial_control_port_pkg::master_state_e m_state;
	logic [2:0] bit_cnt_reg;
	logic sck_reg;
	logic tx_reg;
	logic push_reg;
	logic ss_s1_reg;
	logic ss_s2_reg;
	logic ss_s3_reg;
	logic ck_s1_reg;
	logic ck_s2_reg;
	logic ck_s3_reg;
	logic sck_oe_n_reg;
	logic sel0_oe_n_reg;
	logic sel0_out_reg;
	logic sel1_out_reg;
	logic sel1_oe_n_reg;
	logic tx_oe_n_reg;
	// ==========================================================
	// Decoding and shared terms.
	logic wr_data;
	logic wr_ctrl;
	logic rd_fifo;
	logic baud_tick;
	logic master_mode;
	logic slave_mode;
	logic slave_sel;
	logic busy;
	logic m_done;
	logic m_sample;
	logic m_drive;
	logic ck_rise;
	logic ck_fall;
	logic s_drive;
	logic s_sample;
	logic s_done;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [WB-1:0] fifo_out_data;
	logic [LW-1:0] fifo_level;
	assign wr_data = host_req.wr && host_req.addr == serial_control_port_pkg::ADDR_DATA;
	assign wr_ctrl = host_req.wr && host_req.addr == serial_control_port_pkg::ADDR_CTRL;
	assign rd_fifo = host_req.rd && host_req.addr == serial_control_port_pkg::ADDR_RX_FIFO;
	assign master_mode = en0_reg && !slave_reg;
	assign slave_mode = en0_reg && slave_reg;
	assign slave_sel = slave_mode && !ss_s2_reg;
	assign busy = (m_state != serial_control_port_pkg::M_IDLE) || slave_sel; // see R02
	assign m_sample = m_state == serial_control_port_pkg::M_RUN && baud_tick
		&& (sck_reg != clock_invert_reg);
	assign m_drive = baud_tick && (m_state == serial_control_port_pkg::M_WAIT
		|| (m_state == serial_control_port_pkg::M_RUN && sck_reg == clock_invert_reg));
	assign m_done = m_sample && bit_cnt_reg == 3'd7; // see R10
	assign ck_rise = ck_s2_reg && !ck_s3_reg;
	assign ck_fall = !ck_s2_reg && ck_s3_reg;
	assign s_drive = slave_sel && (clock_invert_reg ? ck_fall : ck_rise); // see R17
	assign s_sample = slave_sel && (clock_invert_reg ? ck_rise : ck_fall); // see R16
	assign s_done = slave_mode && ss_s2_reg && !ss_s3_reg; // see R18
	baud_tap_divider u_div (
		.mclk(mclk),
		.rst_n(rst_n),
		.rate(rate_reg),
		.tick(baud_tick)
	); // see R03
	rx_word_fifo #(
		.WIDTH(WB),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(mclk),
		.rst_n(rst_n),
		.in_valid(push_reg),
		.in_ready(fifo_in_ready),
		.in_data(shift_reg),
		.out_valid(fifo_out_valid),
		.out_ready(rd_fifo),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);
	// ==========================================================
	// Channel configuration registers.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			en0_reg <= 1'b0;
			slave_reg <= 1'b0;
			en1_reg <= 1'b0;
		end
		else if (host_req.wr && host_req.addr == serial_control_port_pkg::ADDR_CH0_SIC)
		begin
			en0_reg <= host_req.wdata[serial_control_port_pkg::SIC_PORT_EN];
			slave_reg <= host_req.wdata[serial_control_port_pkg::SIC_SLAVE];
		end
		else if (host_req.wr && host_req.addr == serial_control_port_pkg::ADDR_CH1_SIC)
			en1_reg <= host_req.wdata[serial_control_port_pkg::SIC_PORT_EN];
	end
	// ==========================================================
	// Status and control register.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			sel0_n_reg <= 1'b1;
			sel1_n_reg <= 1'b1;
			xmit_reg <= 1'b0;
			done_reg <= 1'b0;
			ie_reg <= 1'b0;
			clock_invert_reg <= 1'b0;
			rate_reg <= 2'd0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				sel0_n_reg <= !host_req.wdata[serial_control_port_pkg::CTRL_SEL0]; // see R12
				sel1_n_reg <= !host_req.wdata[serial_control_port_pkg::CTRL_SEL1]; // see R12
				ie_reg <= host_req.wdata[serial_control_port_pkg::CTRL_IE];
				clock_invert_reg <= host_req.wdata[serial_control_port_pkg::CTRL_CLOCK_INVERT];
				rate_reg <= host_req.wdata[serial_control_port_pkg::CTRL_RATE_LO +: 2];
			end
			if (m_done)
				xmit_reg <= 1'b0; // see R10
			else if (wr_ctrl)
				xmit_reg <= host_req.wdata[serial_control_port_pkg::CTRL_XMIT]; // see R09
			if (m_done || s_done)
				done_reg <= 1'b1; // see R10
			else if (wr_ctrl && host_req.wdata[serial_control_port_pkg::CTRL_DONE])
				done_reg <= 1'b0;
		end
	end
	// ==========================================================
	// Master sequencer: waits for a baud tick, then eight clock pulses.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			m_state <= serial_control_port_pkg::M_IDLE;
			bit_cnt_reg <= 3'd0;
			sck_reg <= 1'b0;
		end
		else
		begin
			case (m_state)
				serial_control_port_pkg::M_IDLE:
				begin
					sck_reg <= clock_invert_reg; // see R06
					bit_cnt_reg <= 3'd0;
					if (master_mode && xmit_reg && fifo_in_ready)
						m_state <= serial_control_port_pkg::M_WAIT; // see R13
				end
				serial_control_port_pkg::M_WAIT:
				begin
					if (baud_tick)
					begin
						sck_reg <= !clock_invert_reg; // see R07 R08
						m_state <= serial_control_port_pkg::M_RUN;
					end
				end
				serial_control_port_pkg::M_RUN:
				begin
					if (baud_tick)
					begin
						sck_reg <= !sck_reg;
						if (sck_reg != clock_invert_reg)
						begin
							bit_cnt_reg <= bit_cnt_reg + 3'd1;
							if (bit_cnt_reg == 3'd7)
								m_state <= serial_control_port_pkg::M_IDLE; // see R06
						end
					end
				end
				default:
					m_state <= serial_control_port_pkg::M_IDLE;
			endcase
		end
	end
	// ==========================================================
	// Shift register shared by host, master and slave.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			shift_reg <= serial_control_port_pkg::RESET_BYTE;
		else if (wr_data && !busy)
			shift_reg <= host_req.wdata; // see R02 R09
		else if (m_sample || s_sample)
			shift_reg <= {shift_reg[WB-2:0], port_serial_in}; // see R01 R09 R19 R20
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			tx_reg <= 1'b0;
		else if (m_drive || s_drive)
			tx_reg <= shift_reg[WB-1]; // see R07 R17 R20
	end
	// ==========================================================
	// Completed words go to the receive FIFO; a slave word that finds it full is dropped and sets overflow.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			push_reg <= 1'b0;
			ovr_reg <= 1'b0;
		end
		else
		begin
			push_reg <= m_done || (s_done && fifo_in_ready);
			if (s_done && !fifo_in_ready)
				ovr_reg <= 1'b1;
			else if (host_req.wr && host_req.addr == serial_control_port_pkg::ADDR_FIFO_STAT
				&& host_req.wdata[serial_control_port_pkg::STAT_OVR])
				ovr_reg <= 1'b0;
		end
	end
	// ==========================================================
	// Slave input synchronisers; edges are found between the second and third stages.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ss_s1_reg <= 1'b1;
			ss_s2_reg <= 1'b1;
			ss_s3_reg <= 1'b1;
			ck_s1_reg <= 1'b0;
			ck_s2_reg <= 1'b0;
			ck_s3_reg <= 1'b0;
		end
		else
		begin
			ss_s1_reg <= select_out_0_in; // see R22
			ss_s2_reg <= ss_s1_reg;
			ss_s3_reg <= ss_s2_reg;
			ck_s1_reg <= port_shift_clock_in; // see R22
			ck_s2_reg <= ck_s1_reg;
			ck_s3_reg <= ck_s2_reg;
		end
	end
	// ==========================================================
	// Pin muxing; enables are low while the pin is driven.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			sck_oe_n_reg <= 1'b1;
			sel0_oe_n_reg <= 1'b1;
			sel0_out_reg <= 1'b1;
			sel1_out_reg <= 1'b1;
			sel1_oe_n_reg <= 1'b1;
			tx_oe_n_reg <= 1'b1;
			irq_reg <= 1'b0;
		end
		else
		begin
			sck_oe_n_reg <= !master_mode; // see R04 R15
			sel0_oe_n_reg <= !master_mode; // see R04 R15
			tx_oe_n_reg <= !en0_reg; // see R04
			sel0_out_reg <= wr_ctrl ? !host_req.wdata[serial_control_port_pkg::CTRL_SEL0]
				: sel0_n_reg; // see R12
			sel1_out_reg <= wr_ctrl ? !host_req.wdata[serial_control_port_pkg::CTRL_SEL1]
				: sel1_n_reg; // see R12
			sel1_oe_n_reg <= !en1_reg; // see R05 R15
			irq_reg <= (done_reg || m_done || s_done) && ie_reg; // see R11
		end
	end
	// ==========================================================
	// Host read data.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			rdata_reg <= 8'h00;
		else if (host_req.rd)
		begin
			case (host_req.addr)
				serial_control_port_pkg::ADDR_CH0_SIC:
					rdata_reg <= {6'h00, slave_reg, en0_reg};
				serial_control_port_pkg::ADDR_CH1_SIC:
					rdata_reg <= {7'h00, en1_reg};
				serial_control_port_pkg::ADDR_DATA:
					rdata_reg <= busy ? serial_control_port_pkg::BUSY_READ : shift_reg; // see R02
				serial_control_port_pkg::ADDR_CTRL:
					rdata_reg <= {rate_reg, clock_invert_reg, ie_reg, done_reg, xmit_reg,
						!sel1_n_reg, !sel0_n_reg};
				serial_control_port_pkg::ADDR_RX_FIFO:
					rdata_reg <= fifo_out_valid ? fifo_out_data : 8'h00;
				serial_control_port_pkg::ADDR_FIFO_STAT:
					rdata_reg <= {ovr_reg, 7'(fifo_level)};
				default:
					rdata_reg <= 8'h00;
			endcase
		end
	end
	assign host_rdata = rdata_reg;
	assign irq = irq_reg;
	assign port_serial_out = tx_reg;
	assign port_serial_out_oe_n = tx_oe_n_reg;
	assign port_shift_clock_out = sck_reg;
	assign port_shift_clock_oe_n = sck_oe_n_reg;
	assign select_out_0_out = sel0_out_reg;
	assign select_out_0_oe_n = sel0_oe_n_reg;
	assign select_out_1 = sel1_out_reg;
	assign select_out_1_oe_n = sel1_oe_n_reg;
endmodule
`default_nettype wire

//--- scp_checker_assertions.sv
// Concurrent checks on the serial control port's pins and host bus.
`default_nettype none
module port_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire serial_control_port_pkg::host_req_s host_req,
	input wire logic [7:0] host_rdata,
	input wire logic irq,
	input wire logic port_serial_out_oe_n,
	input wire logic port_shift_clock_out,
	input wire logic port_shift_clock_oe_n,
	input wire logic select_out_0_in,
	input wire logic select_out_0_out,
	input wire logic select_out_0_oe_n,
	input wire logic select_out_1,
	input wire logic select_out_1_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic ctl_wr;
	logic sic0_wr;
	logic ie_q;
	logic invert_q;
	logic [4:0] sck_cnt;
	assign ctl_wr = host_req.wr && host_req.addr == serial_control_port_pkg::ADDR_CTRL;
	assign sic0_wr = host_req.wr && host_req.addr == serial_control_port_pkg::ADDR_CH0_SIC;
	// ==========================================================
	// Shadow of the control bits and a count of clock pin changes per burst.
	always_ff @(posedge mclk)
		if (!rst_n)
			{invert_q, ie_q} <= 2'b00;
		else if (ctl_wr)
			{invert_q, ie_q} <= {host_req.wdata[serial_control_port_pkg::CTRL_CLOCK_INVERT],
				host_req.wdata[serial_control_port_pkg::CTRL_IE]};
	always_ff @(posedge mclk)
		if (!rst_n || (ctl_wr && host_req.wdata[2]))
			sck_cnt <= 5'd0;
		else if ($changed(port_shift_clock_out) && sck_cnt != 5'd31)
			sck_cnt <= sck_cnt + 5'd1;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Assertions.
	a_sel0_follows_bit: assert property (ctl_wr && !select_out_0_oe_n
		|=> select_out_0_out == !$past(host_req.wdata[0])) else $error("select 0 lags its bit");
	a_sel1_follows_bit: assert property (ctl_wr && !select_out_1_oe_n
		|=> select_out_1 == !$past(host_req.wdata[1])) else $error("select 1 lags its bit");
	a_port_enable_out: assert property (sic0_wr
		|=> ##1 port_serial_out_oe_n == !$past(host_req.wdata[0], 2))
		else $error("port enable ignored");
	a_slave_pins_in: assert property (sic0_wr && host_req.wdata[1:0] == 2'b11
		|=> ##1 port_shift_clock_oe_n && select_out_0_oe_n)
		else $error("slave pins still driven");
	a_burst_eight_pulses: assert property ($rose(irq) && !port_shift_clock_oe_n
		|=> sck_cnt == 5'd16 && port_shift_clock_out == invert_q)
		else $error("burst edge count");
	a_irq_gated_enable: assert property (!$past(ie_q) |-> !irq)
		else $error("irq without enable");
	a_unmapped_reads_zero: assert property (host_req.rd && host_req.addr == 8'h7f
		|=> host_rdata == 8'h00) else $error("unmapped read not zero");
	a_slave_done_irq: assert property (port_shift_clock_oe_n && ie_q && $rose(select_out_0_in)
		|-> ##[3:6] irq) else $error("slave completion missing");
	a_reset_pins_quiet: assert property ($rose(rst_n) |-> !irq && host_rdata == 8'h00
		&& port_shift_clock_oe_n && select_out_0_oe_n && select_out_1_oe_n && select_out_1
		&& select_out_0_out) else $error("pins active after reset");
	cover property ($rose(irq) && !port_shift_clock_oe_n);
	cover property ($rose(irq) && port_shift_clock_oe_n);
	cover property (ctl_wr && host_req.wdata[5] && host_req.wdata[2]);
endmodule
`default_nettype wire

//--- scp_peer_model.sv
// Behavioural model of an external serial peripheral on the port's far side.
`default_nettype none
module port_peer_model (
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic clock_invert,
	input wire logic [7:0] tx_byte,
	output logic miso,
	output logic [7:0] rx_byte
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] sh;
	initial
	begin
		miso = 1'b0;
		rx_byte = 8'h00;
		sh = 8'h00;
	end
	always @(negedge cs_n)
		sh = tx_byte;
	// Bits leave on the leading edge; the master's bits are taken on the trailing edge.
	always @(sck)
	begin
		if (!cs_n && sck != clock_invert)
		begin
			miso = sh[7];
			sh = {sh[6:0], 1'b0};
		end
		else if (!cs_n)
			rx_byte = {rx_byte[6:0], mosi};
	end
	// A released line shows the opposite of its last level, not a held value.
	always @(posedge cs_n)
		miso = ~miso;
endmodule
`default_nettype wire

//--- serial_control_port_test.sv
// Self-checking testbench of the serial control port.
`default_nettype none
module serial_control_port_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] A_DAT = serial_control_port_pkg::ADDR_DATA;
	localparam logic [7:0] A_CTL = serial_control_port_pkg::ADDR_CTRL;
	localparam logic [7:0] A_FIFO = serial_control_port_pkg::ADDR_RX_FIFO;
	localparam logic [7:0] A_FST = serial_control_port_pkg::ADDR_FIFO_STAT;
	localparam logic [7:0] RST_ADDR [6] = '{8'h20, 8'h40, 8'h48, 8'h49, 8'h4b, 8'h7f};
	logic mclk, rst_n, irq, sdo, sdo_oe_n, sck_o, sck_oe_n, sel0_o, sel0_oe_n, sel1, sel1_oe_n;
	logic b_sck, b_sel, sdi, slv, miso, clock_invert;
	logic [7:0] rdata, p_tx, p_rx;
	serial_control_port_pkg::host_req_s req;
	wire logic sck_w = sck_oe_n ? b_sck : sck_o;
	wire logic sel_w = sel0_oe_n ? b_sel : sel0_o;
	wire logic sin_w = slv ? sdi : miso;
	int num_errors, n_compared;
	logic [7:0] exp_q[$];
	serial_control_port DUT (.mclk(mclk), .rst_n(rst_n), .host_req(req), .host_rdata(rdata),
		.irq(irq), .port_serial_in(sin_w), .port_serial_out(sdo), .port_serial_out_oe_n(sdo_oe_n),
		.port_shift_clock_in(sck_w), .port_shift_clock_out(sck_o), .port_shift_clock_oe_n(sck_oe_n),
		.select_out_0_in(sel_w), .select_out_0_out(sel0_o), .select_out_0_oe_n(sel0_oe_n),
		.select_out_1(sel1), .select_out_1_oe_n(sel1_oe_n));
	port_peer_model peer (.sck(sck_w), .cs_n(sel_w), .mosi(sdo), .clock_invert(clock_invert),
		.tx_byte(p_tx), .miso(miso), .rx_byte(p_rx));
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// ==========================================================
	// Host bus and comparison tasks.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		req = '0;
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req = '{1'b1, 1'b0, a, d};
		@(posedge mclk);
		#1;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		req = '{1'b0, 1'b1, a, 8'h00};
		@(posedge mclk);
		#1 chk(rdata, e);
	endtask
	task automatic wait_irq;
		int n;
		req = '0;
		n = 0;
		while (irq !== 1'b1 && n < 600)
		begin
			@(posedge mclk);
			#1 n++;
		end
		chk({7'h00, irq}, 8'h01);
		cyc(26);
	endtask
	task automatic xfer(input logic [7:0] ctl, input logic [7:0] d, input logic [7:0] pd);
		int n;
		p_tx = pd;
		clock_invert = ctl[serial_control_port_pkg::CTRL_CLOCK_INVERT];
		wr(A_DAT, d);
		wr(A_CTL, ctl);
		wr(A_CTL, ctl | 8'h01);
		wr(A_CTL, ctl | 8'h05);
		req = '0;
		n = 0;
		while (sck_o === clock_invert && n < 40)
		begin
			@(posedge mclk);
			#1 n++;
		end
		chk({7'h00, n <= 3 * (1 << ctl[7:6]) + 3}, 8'h01);
		rc(A_DAT, 8'h00);
		wr(A_DAT, 8'hff);
		rc(A_CTL, ctl | 8'h05);
		wait_irq();
		rc(A_CTL, ctl | 8'h09);
		rc(A_DAT, pd);
		chk(p_rx, d);
		exp_q.push_back(pd);
		wr(A_CTL, ctl & 8'hef);
		cyc(2);
		chk({7'h00, irq}, 8'h00);
		wr(A_CTL, ctl | 8'h08);
	endtask
	task automatic stop_test;
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		stop_test();
	end
	// ==========================================================
	// Test sequence.
	initial
	begin
		{req, b_sck, sdi, slv, clock_invert, p_tx, num_errors, n_compared} = '0;
		{rst_n, b_sel} = 2'b01;
		repeat (8) @(posedge mclk);
		#1 rst_n = 1'b1;
		foreach (RST_ADDR[i])
			rc(RST_ADDR[i], 8'h00);
		wr(8'h40, 8'h01);
		rc(8'h40, 8'h01);
		wr(A_CTL, 8'h02);
		chk({sel1, sel1_oe_n}, 2'b00);
		wr(A_CTL, 8'h00);
		wr(8'h20, 8'h01);
		cyc(1);
		chk({sel1, sdo_oe_n}, 2'b10);
		$display("registers done");
		for (int r = 0; r < 4; r++)
			xfer({r[1:0], r[0], 5'h10}, 8'h3c ^ r[7:0], 8'hc3 + r[7:0]);
		$display("master done");
		wr(8'h20, 8'h03);
		wr(A_CTL, 8'h10);
		wr(A_DAT, 8'ha5);
		slv = 1'b1;
		cyc(2);
		b_sel = 1'b0;
		cyc(8);
		for (int i = 0; i < 3; i++)
		begin
			b_sck = 1'b1;
			cyc(6);
			chk({7'h00, sdo}, {7'h00, v_bit(i)});
			sdi = ~i[0];
			cyc(2);
			b_sck = 1'b0;
			cyc(6);
		end
		b_sel = 1'b1;
		wait_irq();
		rc(A_CTL, 8'h18);
		rc(A_DAT, 8'h2d);
		exp_q.push_back(8'h2d);
		wr(A_CTL, 8'h18);
		wr(8'h20, 8'h01);
		slv = 1'b0;
		$display("slave done");
		while (exp_q.size() < 8)
			xfer(8'h10, 8'h55, 8'h80 | exp_q.size());
		rc(A_FST, 8'h08);
		p_tx = 8'h99;
		wr(A_DAT, 8'h66);
		wr(A_CTL, 8'h10);
		wr(A_CTL, 8'h11);
		wr(A_CTL, 8'h15);
		cyc(60);
		rc(A_CTL, 8'h15);
		foreach (exp_q[i])
			rc(A_FIFO, exp_q[i]);
		wait_irq();
		rc(A_DAT, 8'h99);
		chk(p_rx, 8'h66);
		rc(A_FIFO, 8'h99);
		rc(A_FST, 8'h00);
		$display("buffer done");
		stop_test();
	end
	function automatic logic v_bit(input int i);
		logic [7:0] d;
		d = 8'ha5;
		return d[7 - i];
	endfunction
endmodule
bind serial_control_port port_checker u_chk (.mclk(mclk), .rst_n(rst_n), .host_req(host_req),
	.host_rdata(host_rdata), .irq(irq), .port_serial_out_oe_n(port_serial_out_oe_n),
	.port_shift_clock_out(port_shift_clock_out), .port_shift_clock_oe_n(port_shift_clock_oe_n),
	.select_out_0_in(select_out_0_in), .select_out_0_out(select_out_0_out),
	.select_out_0_oe_n(select_out_0_oe_n), .select_out_1(select_out_1),
	.select_out_1_oe_n(select_out_1_oe_n));
`default_nettype wire
